// ### cmf_regs.svh
`ifndef CMF_REGS_SVH
`define CMF_REGS_SVH
// ============================================================
// Register map, byte addresses
`define CMF_OFS_CTRL 8'h00
`define CMF_OFS_OPS 8'h04
`define CMF_OFS_OUT_MIN 8'h08
`define CMF_OFS_OUT_MAX 8'h0C
`define CMF_OFS_RESULT 8'h60
`define CMF_OFS_CHAIN 8'h64
`define CMF_OFS_STATUS 8'h68
// Input i window sits at 8'h10 * (i + 1)
`define CMF_IN_SUB_SRC 2'h0
`define CMF_IN_SUB_MIN 2'h1
`define CMF_IN_SUB_MAX 2'h2
`define CMF_IN_SUB_WGT 2'h3
// ============================================================
// Field positions
`define CMF_CTRL_EN_BIT 0
`define CMF_SRC_TYPE_LSB 0
`define CMF_SRC_NUM_LSB 4
`define CMF_OP_WIDTH 4
// ============================================================
// Reset values
`define CMF_RST_IN_MIN 32'shFFFF_FC18
`define CMF_RST_IN_MAX 32'sh0000_03E8
`define CMF_RST_WGT 16'sh4000
`define CMF_RST_OUT_MIN 32'sh0000_0000
`define CMF_RST_OUT_MAX 32'sh0000_03E8
`define CMF_RST_OPS 16'h0000
// ============================================================
// Arithmetic constants and timing
`define CMF_NORM_LIM 32'sh0000_03E8
`define CMF_NORM_SPAN 32'sh0000_07D0
`define CMF_FULL_SCALE 32'sh000F_4240
`define CMF_WGT_FRAC 14
`define CMF_UPDATE_LATENCY 11
`endif

// ### cmf_pkg.sv
package cmf_pkg;
    typedef logic signed [31:0] cmf_val_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_STAGE = 2'b10,
        ST_OUT = 2'b11
    } cmf_state_e;

    typedef enum logic [3:0] {
        OP_EQ = 4'h0, OP_NE = 4'h1, OP_GT = 4'h2, OP_GE = 4'h3,
        OP_LT = 4'h4, OP_LE = 4'h5, OP_OR = 4'h6, OP_AND = 4'h7,
        OP_XOR = 4'h8, OP_ADD = 4'h9, OP_SUB = 4'hA, OP_MUL = 4'hB,
        OP_DIV = 4'hC, OP_MIN = 4'hD, OP_MAX = 4'hE, OP_ABSDIFF = 4'hF
    } cmf_op_e;
endpackage : cmf_pkg

// ### cmf_scale.sv
`include "cmf_regs.svh"

module cmf_scale (
    input wire cmf_pkg::cmf_val_t raw,
    input wire cmf_pkg::cmf_val_t in_min,
    input wire cmf_pkg::cmf_val_t in_max,
    input wire logic signed [15:0] wgt,
    output cmf_pkg::cmf_val_t weighted
);
    logic signed [63:0] span;
    logic signed [63:0] norm;
    logic signed [63:0] wclip;
    logic signed [63:0] prod;
    logic signed [63:0] lim;
    logic signed [63:0] one;

    always_comb
    begin
        lim = 64'(`CMF_NORM_LIM);
        one = 64'(`CMF_RST_WGT);
        span = 64'(in_max) - 64'(in_min);
        // Degenerate range: keep the raw value rather than divide by zero
        if (span > 64'sh0)
            norm = (64'(raw) - 64'(in_min)) * 64'(`CMF_NORM_SPAN) / span - lim; // RULE3
        else
            norm = 64'(raw);
        if (norm > lim)
            norm = lim; // RULE2
        else if (norm < -lim)
            norm = -lim; // RULE2
        wclip = 64'(wgt);
        if (wclip > one)
            wclip = one; // RULE4
        else if (wclip < -one)
            wclip = -one; // RULE4
        prod = (norm * wclip) >>> `CMF_WGT_FRAC; // RULE4 RULE17
        weighted = 32'(prod);
    end
endmodule : cmf_scale

// ### cmf_stage.sv
`include "cmf_regs.svh"

module cmf_stage (
    input wire cmf_pkg::cmf_op_e op,
    input wire logic b_used,
    input wire cmf_pkg::cmf_val_t operand_a,
    input wire cmf_pkg::cmf_val_t operand_b,
    output cmf_pkg::cmf_val_t result
);
    logic signed [63:0] wa;
    logic signed [63:0] wb;
    logic signed [63:0] wide;
    logic signed [63:0] fs;
    logic ta;
    logic tb;
    logic flag;

    always_comb
    begin
        wa = 64'(operand_a);
        wb = 64'(operand_b);
        fs = 64'(`CMF_FULL_SCALE);
        ta = operand_a >= 32'sh1; // RULE11
        tb = operand_b >= 32'sh1; // RULE11
        flag = 1'b0;
        wide = 64'sh0;
        case (op)
            cmf_pkg::OP_EQ: flag = wa == wb; // RULE7
            cmf_pkg::OP_NE: flag = wa != wb;
            cmf_pkg::OP_GT: flag = wa > wb;
            cmf_pkg::OP_GE: flag = wa >= wb;
            cmf_pkg::OP_LT: flag = wa < wb;
            cmf_pkg::OP_LE: flag = wa <= wb;
            cmf_pkg::OP_OR: flag = ta | tb; // RULE8
            cmf_pkg::OP_AND: flag = ta & tb;
            cmf_pkg::OP_XOR: flag = ta ^ tb;
            cmf_pkg::OP_ADD: wide = wa + wb; // RULE9
            cmf_pkg::OP_SUB: wide = wa - wb;
            cmf_pkg::OP_MUL: wide = wa * wb;
            cmf_pkg::OP_DIV: wide = (wb == 64'sh0) ? fs : wa / wb; // RULE14
            cmf_pkg::OP_MIN: wide = (wa < wb) ? wa : wb; // RULE10
            cmf_pkg::OP_MAX: wide = (wa > wb) ? wa : wb;
            cmf_pkg::OP_ABSDIFF: wide = (wa > wb) ? wa - wb : wb - wa;
            default: wide = 64'sh0;
        endcase
        if (wide > fs)
            wide = fs; // RULE13
        else if (wide < -fs)
            wide = -fs; // RULE13
        if (!b_used)
            result = operand_a; // RULE6
        else if (op >= cmf_pkg::OP_ADD)
            result = 32'(wide);
        else
            result = {31'h0, flag}; // RULE12
    end
endmodule : cmf_stage

// ### cmf_math_block.sv
`include "cmf_regs.svh"

// Operation
// [RULE1] Up to five inputs: A for stage one, one B per stage, by type/number.
// [RULE2] Inputs presented to the stages lie within -1000..+1000.
// [RULE3] Each raw input rescales linearly from its min/max to normal range.
// [RULE4] Each rescaled input is multiplied by a weight -1..+1, default one.
// [RULE5] Stage one takes A and B; later stages take the prior result.
// [RULE6] A stage whose B source type is zero passes A unchanged.
// [RULE7] Codes 0..5 compare A with B: eq, ne, gt, ge, lt, le.
// [RULE8] Codes 6, 7, 8 give logical OR, AND, XOR.
// [RULE9] Codes 9..12 give A plus, minus, times, divided by B.
// [RULE10] Codes 13, 14 give min and max; 15 gives absolute difference.
// [RULE11] For logic codes an operand of at least one counts as true.
// [RULE12] Codes 0..8 yield exactly zero or one.
// [RULE13] Arithmetic results saturate at plus or minus one million.
// [RULE14] Division by zero yields one million.
// [RULE15] Final result maps into the output min/max range.
// [RULE16] Output min/max are reported as limits to consuming blocks.
// [RULE17] Arithmetic runs in signed fixed point wide enough for fractions.
// [RULE18] One chain run per update strobe; output refreshes after last stage.
module cmf_math_block #(
    parameter int N_STAGE = 4
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic upd_stb,
    output logic [2:0] src_type,
    output logic [3:0] src_num,
    input wire cmf_pkg::cmf_val_t src_value,
    output cmf_pkg::cmf_val_t out_value,
    output logic out_valid,
    output cmf_pkg::cmf_val_t lim_min,
    output cmf_pkg::cmf_val_t lim_max,
    output logic busy
);
    localparam int N_IN = N_STAGE + 1;
    if (N_STAGE < 1 || N_STAGE > 4)
    begin : g_bad_stage
        $error("N_STAGE must be 1 to 4");
    end

    // ============================================================
    // Configuration and state
    logic ctrl_en_q, valid_q, rd_pend_q, in_hit, st_bused;
    logic [15:0] ops_q;
    logic [7:0] in_src_q [N_IN];
    logic signed [15:0] in_wgt_q [N_IN];
    cmf_pkg::cmf_val_t in_min_q [N_IN], in_max_q [N_IN], norm_q [N_IN];
    cmf_pkg::cmf_val_t out_min_q, out_max_q, acc_q, out_q, out_d;
    cmf_pkg::cmf_val_t raw, scaled, st_a, st_b, st_res;
    cmf_pkg::cmf_state_e state_q;
    cmf_pkg::cmf_op_e st_op;
    logic [2:0] idx_q, in_idx, b_idx;
    logic [3:0] in_sel;
    logic [31:0] rd_data_q, rd_data_d;
    logic signed [63:0] map_c, map_v;

    function automatic logic [31:0] be_merge(input logic [31:0] old,
        input logic [31:0] wdata, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int k = 0; k < 4; k++)
            if (be[k])
                res[8*k +: 8] = wdata[8*k +: 8];
        return res;
    endfunction : be_merge

    // ============================================================
    // Avalon-MM slave: writes take no wait, reads take one
    assign in_sel = avs_address[7:4];
    assign in_idx = 3'(in_sel - 4'h1);
    assign in_hit = (in_sel != 4'h0) && (32'(in_sel) <= N_IN);
    assign avs_waitrequest = avs_read & ~rd_pend_q;
    assign avs_readdata = rd_data_q;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_en_q <= 1'b0;
            ops_q <= `CMF_RST_OPS;
            out_min_q <= `CMF_RST_OUT_MIN;
            out_max_q <= `CMF_RST_OUT_MAX;
        end
        else if (avs_write)
        begin
            case (avs_address)
                `CMF_OFS_CTRL:
                    if (avs_byteenable[0])
                        ctrl_en_q <= avs_writedata[`CMF_CTRL_EN_BIT];
                `CMF_OFS_OPS:
                    ops_q <= 16'(be_merge({16'h0, ops_q}, avs_writedata,
                                          avs_byteenable));
                `CMF_OFS_OUT_MIN:
                    out_min_q <= be_merge(out_min_q, avs_writedata,
                                          avs_byteenable);
                `CMF_OFS_OUT_MAX:
                    out_max_q <= be_merge(out_max_q, avs_writedata,
                                          avs_byteenable);
                default: ;
            endcase
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++)
        begin : g_in_regs
            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    in_src_q[gi] <= 8'h00;
                    in_min_q[gi] <= `CMF_RST_IN_MIN;
                    in_max_q[gi] <= `CMF_RST_IN_MAX;
                    in_wgt_q[gi] <= `CMF_RST_WGT;
                end
                else if (avs_write && in_hit && in_idx == 3'(gi))
                begin
                    case (avs_address[3:2])
                        `CMF_IN_SUB_SRC:
                            if (avs_byteenable[0])
                                in_src_q[gi] <= avs_writedata[7:0]; // RULE1
                        `CMF_IN_SUB_MIN:
                            in_min_q[gi] <= be_merge(in_min_q[gi],
                                avs_writedata, avs_byteenable); // RULE3
                        `CMF_IN_SUB_MAX:
                            in_max_q[gi] <= be_merge(in_max_q[gi],
                                avs_writedata, avs_byteenable); // RULE3
                        default:
                            in_wgt_q[gi] <= 16'(be_merge({16'h0, in_wgt_q[gi]},
                                avs_writedata, avs_byteenable)); // RULE4
                    endcase
                end
            end
        end
    endgenerate
    // Unmapped addresses read as zero
    always_comb
    begin
        rd_data_d = 32'h0;
        if (in_hit)
        begin
            case (avs_address[3:2])
                `CMF_IN_SUB_SRC: rd_data_d = {24'h0, in_src_q[in_idx]};
                `CMF_IN_SUB_MIN: rd_data_d = in_min_q[in_idx];
                `CMF_IN_SUB_MAX: rd_data_d = in_max_q[in_idx];
                default: rd_data_d = {16'h0, in_wgt_q[in_idx]};
            endcase
        end
        else
        begin
            case (avs_address)
                `CMF_OFS_CTRL: rd_data_d = {31'h0, ctrl_en_q};
                `CMF_OFS_OPS: rd_data_d = {16'h0, ops_q};
                `CMF_OFS_OUT_MIN: rd_data_d = out_min_q;
                `CMF_OFS_OUT_MAX: rd_data_d = out_max_q;
                `CMF_OFS_RESULT: rd_data_d = out_q;
                `CMF_OFS_CHAIN: rd_data_d = acc_q;
                `CMF_OFS_STATUS: rd_data_d = {27'h0, idx_q, state_q};
                default: rd_data_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_pend_q <= 1'b0;
            rd_data_q <= 32'h0;
        end
        else
        begin
            rd_pend_q <= avs_read & ~rd_pend_q;
            if (avs_read && !rd_pend_q)
                rd_data_q <= rd_data_d;
        end
    end

    // ============================================================
    // Sequencer: fetch each input, then run the stages in order
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= cmf_pkg::ST_IDLE;
            idx_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                cmf_pkg::ST_IDLE:
                    if (upd_stb && ctrl_en_q)
                    begin
                        state_q <= cmf_pkg::ST_FETCH; // RULE18
                        idx_q <= 3'h0;
                    end
                cmf_pkg::ST_FETCH:
                    if (32'(idx_q) == N_IN - 1)
                    begin
                        state_q <= cmf_pkg::ST_STAGE;
                        idx_q <= 3'h0;
                    end
                    else
                        idx_q <= idx_q + 3'h1;
                cmf_pkg::ST_STAGE:
                    if (32'(idx_q) == N_STAGE - 1)
                        state_q <= cmf_pkg::ST_OUT;
                    else
                        idx_q <= idx_q + 3'h1;
                default:
                    state_q <= cmf_pkg::ST_IDLE;
            endcase
        end
    end

    // Sources are asked for one at a time; type zero reads as zero
    assign src_type = (state_q == cmf_pkg::ST_FETCH) ?
        in_src_q[idx_q][`CMF_SRC_TYPE_LSB +: 3] : 3'h0; // RULE1
    assign src_num = (state_q == cmf_pkg::ST_FETCH) ?
        in_src_q[idx_q][`CMF_SRC_NUM_LSB +: 4] : 4'h0;
    assign raw = (src_type == 3'h0) ? 32'sh0 : src_value;
    cmf_scale u_scale (
        .raw(raw),
        .in_min(in_min_q[idx_q]),
        .in_max(in_max_q[idx_q]),
        .wgt(in_wgt_q[idx_q]),
        .weighted(scaled)
    );

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int k = 0; k < N_IN; k++)
                norm_q[k] <= 32'sh0;
        end
        else if (state_q == cmf_pkg::ST_FETCH)
            norm_q[idx_q] <= scaled; // RULE2
    end

    // ============================================================
    // Operator chain
    assign b_idx = idx_q + 3'h1;
    assign st_op = cmf_pkg::cmf_op_e'(ops_q[`CMF_OP_WIDTH*idx_q +: 4]);
    assign st_bused = in_src_q[b_idx][`CMF_SRC_TYPE_LSB +: 3] != 3'h0;
    assign st_a = (idx_q == 3'h0) ? norm_q[0] : acc_q; // RULE5
    assign st_b = norm_q[b_idx];
    cmf_stage u_stage (
        .op(st_op),
        .b_used(st_bused),
        .operand_a(st_a),
        .operand_b(st_b),
        .result(st_res)
    );

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            acc_q <= 32'sh0;
        else if (state_q == cmf_pkg::ST_STAGE)
            acc_q <= st_res; // RULE5
    end

    // ============================================================
    // Output mapping: -1000..1000 spans out_min..out_max
    always_comb
    begin
        map_c = 64'(acc_q);
        if (map_c > 64'(`CMF_NORM_LIM))
            map_c = 64'(`CMF_NORM_LIM);
        else if (map_c < -64'(`CMF_NORM_LIM))
            map_c = -64'(`CMF_NORM_LIM);
        map_v = 64'(out_min_q) + (map_c + 64'(`CMF_NORM_LIM)) *
            (64'(out_max_q) - 64'(out_min_q)) / 64'(`CMF_NORM_SPAN);
        out_d = 32'(map_v); // RULE15
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            out_q <= 32'sh0;
            valid_q <= 1'b0;
        end
        else
        begin
            valid_q <= state_q == cmf_pkg::ST_OUT; // RULE18
            if (state_q == cmf_pkg::ST_OUT)
                out_q <= out_d; // RULE15
        end
    end
    assign out_value = out_q;
    assign out_valid = valid_q;
    assign lim_min = out_min_q; // RULE16
    assign lim_max = out_max_q; // RULE16
    assign busy = state_q != cmf_pkg::ST_IDLE;
    // ============================================================
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    a_norm_range: // RULE2
    assert property (state_q == cmf_pkg::ST_FETCH |->
        scaled <= `CMF_NORM_LIM && scaled >= -`CMF_NORM_LIM)
        else $error("input outside normal range");
    a_default_ident: // RULE3
    assert property (state_q == cmf_pkg::ST_FETCH &&
        in_min_q[idx_q] == `CMF_RST_IN_MIN &&
        in_max_q[idx_q] == `CMF_RST_IN_MAX &&
        in_wgt_q[idx_q] == `CMF_RST_WGT && raw <= `CMF_NORM_LIM &&
        raw >= -`CMF_NORM_LIM |-> ##1 norm_q[$past(idx_q)] == $past(raw))
        else $error("default scaling not identity");
    a_chain_link: // RULE5
    assert property (state_q == cmf_pkg::ST_STAGE && idx_q != 3'h0 |->
        st_a == $past(st_res))
        else $error("stage operand not previous result");
    a_unused_pass: // RULE6
    assert property (state_q == cmf_pkg::ST_STAGE && !st_bused |->
        ##1 acc_q == $past(st_a))
        else $error("unused stage altered operand");
    a_cmp_gt: // RULE7
    assert property (st_bused && st_op == cmf_pkg::OP_GT |->
        st_res == {31'h0, st_a > st_b})
        else $error("greater-than wrong");
    a_logic_and: // RULE11
    assert property (st_bused && st_op == cmf_pkg::OP_AND |->
        st_res == {31'h0, st_a >= 32'sh1 && st_b >= 32'sh1})
        else $error("logical and wrong");
    a_bool_result: // RULE12
    assert property (st_bused && st_op <= cmf_pkg::OP_XOR |->
        st_res == 32'sh0 || st_res == 32'sh1)
        else $error("logic result not boolean");
    a_min_pick: // RULE10
    assert property (st_bused && st_op == cmf_pkg::OP_MIN |->
        st_res <= st_a && st_res <= st_b && (st_res == st_a || st_res == st_b))
        else $error("minimum wrong");
    a_sat_bound: // RULE13
    assert property (state_q == cmf_pkg::ST_STAGE |->
        st_res <= `CMF_FULL_SCALE && st_res >= -`CMF_FULL_SCALE)
        else $error("result beyond full scale");
    a_div_zero: // RULE14
    assert property (st_bused && st_op == cmf_pkg::OP_DIV && st_b == 32'sh0
        |-> st_res == `CMF_FULL_SCALE)
        else $error("divide by zero not full scale");
    a_out_range: // RULE15
    assert property (valid_q && $past(out_min_q) <= $past(out_max_q) |->
        out_q >= $past(out_min_q) && out_q <= $past(out_max_q))
        else $error("output outside range");
    a_update_lat: // RULE18
    assert property (state_q == cmf_pkg::ST_IDLE && upd_stb && ctrl_en_q |->
        ##1 !valid_q [*5] ##1 !valid_q [*5] ##1 valid_q ##1 !valid_q)
        else $error("update latency wrong");
    c_div_zero: cover property (st_bused && st_op == cmf_pkg::OP_DIV &&
        st_b == 32'sh0);
    c_saturate: cover property (state_q == cmf_pkg::ST_STAGE &&
        st_res == `CMF_FULL_SCALE);
    c_full_run: cover property (valid_q ##1 busy);
endmodule : cmf_math_block

// ### cmf_src_model.sv
module cmf_src_model (
    input wire logic sys_clk,
    input wire logic [2:0] src_type,
    input wire logic [3:0] src_num,
    output cmf_pkg::cmf_val_t src_value
);
    timeunit 1ns;
    timeprecision 1ps;
    cmf_pkg::cmf_val_t val_mem [0:127];
    cmf_pkg::cmf_val_t junk_q = 32'h5A5A_A5A5;
    // ============================================================
    // Fabric answer
    // No source selected: a changing pattern, never a stale value
    always @(posedge sys_clk)
        junk_q <= ~junk_q;
    assign src_value = (src_type == 3'h0) ? junk_q
        : val_mem[{src_type, src_num}];
endmodule : cmf_src_model

// ### tb_chained_math_function_block.sv
`include "cmf_regs.svh"

module tb_chained_math_function_block;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint FS = 1000000;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic upd_stb = 1'b0;
    logic [2:0] src_type;
    logic [3:0] src_num;
    cmf_pkg::cmf_val_t src_value, out_value, lim_min, lim_max;
    logic out_valid, busy;
    int bad_count = 0;
    int compares = 0;
    int busy_n = 0;

    always #2.5 sys_clk = ~sys_clk;

    cmf_math_block #(.N_STAGE(4)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .upd_stb(upd_stb),
        .src_type(src_type), .src_num(src_num), .src_value(src_value),
        .out_value(out_value), .out_valid(out_valid), .lim_min(lim_min),
        .lim_max(lim_max), .busy(busy));

    cmf_src_model src_u (.sys_clk(sys_clk), .src_type(src_type),
        .src_num(src_num), .src_value(src_value));

    // ============================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        while (!done)
        begin
            // Sample where settled; inputs only move at rising edges
            @(negedge sys_clk);
            done = (avs_waitrequest === 1'b0);
            rd = avs_readdata;
            @(posedge sys_clk);
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask : rd

    task automatic cfg_in(input int i, input logic [2:0] ty, input int v);
        src_u.val_mem[{ty, 4'(i + 1)}] = v;
        wr(8'((i + 1) * 16), {24'h0, 4'(i + 1), 1'b0, ty});
    endtask : cfg_in

    // Index of the single out_valid pulse; 99 none, 98 more than one
    task automatic run(output int n);
        n = 99;
        busy_n = 0;
        @(posedge sys_clk);
        upd_stb <= 1'b1;
        for (int i = 0; i < 30; i++)
        begin
            @(negedge sys_clk);
            if (out_valid === 1'b1)
                n = (n == 99) ? i : 98;
            if (busy === 1'b1)
                busy_n++;
            @(posedge sys_clk);
            upd_stb <= (i == 3);
        end
    endtask : run

    function automatic longint ref_op(input int op, input longint a,
        input longint b);
        longint r;
        case (op)
            0: r = a == b;
            1: r = a != b;
            2: r = a > b;
            3: r = a >= b;
            4: r = a < b;
            5: r = a <= b;
            6: r = (a >= 1) || (b >= 1);
            7: r = (a >= 1) && (b >= 1);
            8: r = (a >= 1) != (b >= 1);
            9: r = a + b;
            10: r = a - b;
            11: r = a * b;
            12: r = (b == 0) ? FS : a / b;
            13: r = (a < b) ? a : b;
            14: r = (a > b) ? a : b;
            default: r = (a > b) ? a - b : b - a;
        endcase
        if (op > 8)
            r = (r > FS) ? FS : (r < -FS) ? -FS : r;
        return r;
    endfunction : ref_op

    function automatic longint mapv(input longint r, input longint mn,
        input longint mx);
        longint c;
        c = (r > 1000) ? 1000 : (r < -1000) ? -1000 : r;
        return mn + (c + 1000) * (mx - mn) / 2000;
    endfunction : mapv

    // ============================================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] d;
        rd(`CMF_OFS_OUT_MAX, d);
        chk("out_max", d, 32'h3E8);
        rd(8'h14, d);
        chk("in_min", d, 32'hFFFF_FC18);
        rd(8'h1C, d);
        chk("weight", d, 32'h4000);
        rd(8'h70, d);
        chk("unmapped", d, 32'h0);
        wr(`CMF_OFS_RESULT, 32'h1234);
        rd(`CMF_OFS_RESULT, d);
        chk("result_ro", d, 32'h0);
        chk("lim_max", lim_max, 32'h3E8);
    endtask : t_reset

    task automatic t_ops;
        logic [31:0] d;
        int n;
        longint e;
        wr(`CMF_OFS_CTRL, 32'h1);
        cfg_in(0, 3'h2, 300);
        cfg_in(1, 3'h2, -200);
        for (int i = 2; i < 5; i++)
            cfg_in(i, 3'h0, 0);
        for (int op = 0; op < 16; op++)
        begin
            wr(`CMF_OFS_OPS, 32'(op));
            run(n);
            chk("latency", 32'(n), 32'hB);
            rd(`CMF_OFS_CHAIN, d);
            e = ref_op(op, 300, -200);
            chk("chain", d, 32'(e));
            chk("out", out_value, 32'(mapv(e, 0, 1000)));
        end
    endtask : t_ops

    task automatic t_chain;
        logic [31:0] d;
        int n;
        // Raw 5000 lands beyond the normal range and must clamp
        cfg_in(0, 3'h2, 5000);
        cfg_in(1, 3'h2, 1000);
        cfg_in(2, 3'h2, 1000);
        cfg_in(3, 3'h2, 0);
        cfg_in(4, 3'h0, 0);
        wr(`CMF_OFS_OPS, 32'h0C9B);
        run(n);
        chk("latency", 32'(n), 32'hB);
        rd(`CMF_OFS_CHAIN, d);
        chk("chain", d, 32'h000F_4240);
        chk("busy", 32'(busy_n), 32'hA);
        chk("out", out_value, 32'h3E8);
    endtask : t_chain

    task automatic t_scale;
        logic [31:0] d;
        int n;
        cfg_in(0, 3'h2, 3000);
        wr(8'h14, 32'h0);
        wr(8'h18, 32'hFA0);
        wr(8'h1C, 32'h2000);
        cfg_in(1, 3'h0, 0);
        cfg_in(2, 3'h0, 0);
        cfg_in(3, 3'h0, 0);
        wr(`CMF_OFS_OPS, 32'h0);
        wr(`CMF_OFS_OUT_MIN, 32'hFFFF_FE0C);
        wr(`CMF_OFS_OUT_MAX, 32'h5DC);
        run(n);
        rd(`CMF_OFS_CHAIN, d);
        chk("chain", d, 32'hFA);
        chk("out", out_value, 32'h2EE);
        chk("lim_min", lim_min, 32'hFFFF_FE0C);
        chk("lim_max", lim_max, 32'h5DC);
    endtask : t_scale

    task automatic t_off;
        int n;
        wr(`CMF_OFS_CTRL, 32'h0);
        run(n);
        chk("disabled", 32'(n), 32'h63);
        chk("busy", 32'(busy_n), 32'h0);
    endtask : t_off

    task automatic end_sim;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_ops();
        t_chain();
        t_scale();
        t_off();
        end_sim();
    end

    // Whole run needs under a thousand cycles
    initial
    begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule : tb_chained_math_function_block
